// ### src/regconv_pkg.sv
// Constants, field layouts and carriers for the register-convention bank.
// Assumes one 50 MHz system clock and a synchronous active-high reset.
//
// Overview of operation
// - A read/write bit reads back what software last stored in it.
// - A read-only bit ignores writes and still reports its current value.
// - A write-only bit takes writes but its read value is not to be relied on.
// - Every reserved bit position reads back as zero whatever was written.
// - A read-only multi-bit field only ever shows one of its defined encodings.
// - Registers load reset values on power reset, peripheral ones also on soft reset.
// - Debug control keeps its contents across a peripheral soft reset.
// - A one written to the clear alias clears that shared bit in both views.
// - A one written to the set alias sets that shared bit in both views.
// - Both views of a set/clear pair read the same shared value.
// - A set and a clear of the same bit in one cycle leave the bit cleared.

package regconv_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL        = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS      = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CMD         = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_DBGCTRL     = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_SET   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CLEAR_ALIAS = 4'h5;

  // ----------------------------------------------------------------
  // Field positions and implemented-bit masks
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int STAT_EN_BIT    = 0;
  localparam int STAT_MODE_LSB  = 1;
  localparam int STAT_EXT_BIT   = 3;
  localparam int CMD_SRST_BIT   = 0;
  localparam int DBG_RUN_BIT    = 0;
  localparam logic [DATA_W-1:0] CTRL_USED_MASK = 8'h07;
  localparam logic [DATA_W-1:0] DBG_USED_MASK  = 8'h01;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [DATA_W-1:0] DBG_RST   = 8'h00;
  localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
  localparam logic              EXT_RST   = 1'h0;

  // ----------------------------------------------------------------
  // Mode field encodings (code 3 is reserved)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE   = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_CONT   = 2'h2
  } mode_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } reg_rsp_t;

endpackage : regconv_pkg

// ### src/setclr_bank.sv
// Shared storage behind a set/clear alias pair, one flip-flop per bit.
// Assumes set and clear masks are already decoded from both write ports.
`timescale 1ns/1ps

module setclr_bank
  import regconv_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              srst_i,
  input  wire logic [DATA_W-1:0] set_i,
  input  wire logic [DATA_W-1:0] clr_i,
  output logic      [DATA_W-1:0] value_o
);

  // ----------------------------------------------------------------
  // Per-bit storage
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    always_ff @(posedge clk_sys_i) begin
      if (rst_i || srst_i) begin
        value_o[i] <= FLAGS_RST[i];
      end else if (clr_i[i]) begin
        value_o[i] <= 1'h0;
      end else if (set_i[i]) begin
        value_o[i] <= 1'h1;
      end
      // Zero in both masks holds the bit
    end
  end

endmodule : setclr_bank

// ### src/regconv_bank.sv
// Register bank showing read/write, read-only, write-only, reserved and
// set/clear alias behaviour, with peripheral soft reset and debug control.
// Assumes two same-clock access ports and one asynchronous status pin.
`timescale 1ns/1ps

module regconv_bank
  import regconv_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire reg_req_t          req_a_i,
  input  wire reg_req_t          req_b_i,
  input  wire logic              ext_flag_i,
  output reg_rsp_t               rsp_o,
  output logic                   ctrl_enable_o,
  output logic      [1:0]        ctrl_mode_o,
  output logic                   dbg_run_o,
  output logic      [DATA_W-1:0] flags_o
);

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic              wr_a;
  logic              wr_b;
  logic              rd_a;
  logic              srst;
  logic [DATA_W-1:0] set_mask;
  logic [DATA_W-1:0] clr_mask;
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] dbg_reg;
  logic [DATA_W-1:0] status_value;
  logic [DATA_W-1:0] rd_data_next;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic              ext_s1_reg;
  logic              ext_s2_reg;
  logic              ext_s3_reg;
  logic              ext_level_reg;
  mode_t             mode_shown;

  assign wr_a = req_a_i.valid && req_a_i.write;
  assign wr_b = req_b_i.valid && req_b_i.write;
  assign rd_a = req_a_i.valid && !req_a_i.write;

  // Peripheral soft reset from the write-only command register
  assign srst = (wr_a && req_a_i.addr == OFS_CMD && req_a_i.wdata[CMD_SRST_BIT])
             || (wr_b && req_b_i.addr == OFS_CMD && req_b_i.wdata[CMD_SRST_BIT]);

  // Set and clear masks merged from both ports
  always_comb begin
    set_mask = '0;
    clr_mask = '0;
    if (wr_a && req_a_i.addr == OFS_FLAGS_SET) begin
      set_mask = set_mask | req_a_i.wdata;
    end
    if (wr_b && req_b_i.addr == OFS_FLAGS_SET) begin
      set_mask = set_mask | req_b_i.wdata;
    end
    if (wr_a && req_a_i.addr == OFS_CLEAR_ALIAS) begin
      clr_mask = clr_mask | req_a_i.wdata;
    end
    if (wr_b && req_b_i.addr == OFS_CLEAR_ALIAS) begin
      clr_mask = clr_mask | req_b_i.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Control register (read/write, soft-reset domain)
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || srst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_b && req_b_i.addr == OFS_CTRL) begin
      ctrl_reg <= req_b_i.wdata & CTRL_USED_MASK;
    end else if (wr_a && req_a_i.addr == OFS_CTRL) begin
      ctrl_reg <= req_a_i.wdata & CTRL_USED_MASK;
    end
  end

  assign ctrl_enable_o = ctrl_reg[CTRL_EN_BIT];
  assign ctrl_mode_o   = ctrl_reg[CTRL_MODE_LSB +: 2];

  // ----------------------------------------------------------------
  // Debug control register (power reset only)
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dbg_reg <= DBG_RST;
    end else if (wr_b && req_b_i.addr == OFS_DBGCTRL) begin
      dbg_reg <= req_b_i.wdata & DBG_USED_MASK;
    end else if (wr_a && req_a_i.addr == OFS_DBGCTRL) begin
      dbg_reg <= req_a_i.wdata & DBG_USED_MASK;
    end
  end

  assign dbg_run_o = dbg_reg[DBG_RUN_BIT];

  // ----------------------------------------------------------------
  // Set/clear shared flags
  // ----------------------------------------------------------------
  setclr_bank u_flags (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .srst_i    (srst),
    .set_i     (set_mask),
    .clr_i     (clr_mask),
    .value_o   (flags_o)
  );

  // ----------------------------------------------------------------
  // Status pin synchroniser and filter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ext_s1_reg <= EXT_RST;
      ext_s2_reg <= EXT_RST;
      ext_s3_reg <= EXT_RST;
    end else begin
      ext_s1_reg <= ext_flag_i;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || srst) begin
      ext_level_reg <= EXT_RST;
    end else if (ext_s2_reg == ext_s3_reg) begin
      ext_level_reg <= ext_s3_reg;
    end
  end

  // ----------------------------------------------------------------
  // Status view (read-only)
  // ----------------------------------------------------------------
  // A stored reserved mode code is reported as idle
  always_comb begin
    mode_shown = MODE_IDLE;
    if (ctrl_reg[CTRL_EN_BIT]) begin
      unique case (ctrl_reg[CTRL_MODE_LSB +: 2])
        MODE_SINGLE: mode_shown = MODE_SINGLE;
        MODE_CONT:   mode_shown = MODE_CONT;
        default:     mode_shown = MODE_IDLE;
      endcase
    end
  end

  always_comb begin
    status_value = '0;
    status_value[STAT_EN_BIT] = ctrl_reg[CTRL_EN_BIT];
    status_value[STAT_MODE_LSB +: 2] = mode_shown;
    status_value[STAT_EXT_BIT] = ext_level_reg;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_next = '0;
    unique case (req_a_i.addr)
      OFS_CTRL:        rd_data_next = ctrl_reg & CTRL_USED_MASK;
      OFS_STATUS:      rd_data_next = status_value;
      OFS_CMD:         rd_data_next = '0;
      OFS_DBGCTRL:     rd_data_next = dbg_reg & DBG_USED_MASK;
      OFS_FLAGS_SET:   rd_data_next = flags_o;
      OFS_CLEAR_ALIAS: rd_data_next = flags_o;
      default:         rd_data_next = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= rd_a;
      rsp_o.data  <= rd_a ? rd_data_next : '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_addr_reg <= '0;
    end else if (rd_a) begin
      rd_addr_reg <= req_a_i.addr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_ctrl_write_a;
    wr_a && req_a_i.addr == OFS_CTRL && !wr_b && !srst;
  endsequence

  sequence s_ctrl_read_back;
    rd_a && req_a_i.addr == OFS_CTRL && !wr_b;
  endsequence

  chk_rw_readback: assert property (
    s_ctrl_write_a ##1 s_ctrl_read_back
    |=> rsp_o.valid && rsp_o.data == ($past(req_a_i.wdata, 2) & CTRL_USED_MASK))
    else $error("control register read back differs from write");

  chk_ro_ignored: assert property (
    wr_a && req_a_i.addr == OFS_STATUS && !wr_b
    |=> $stable(ctrl_reg) && $stable(dbg_reg) && $stable(flags_o))
    else $error("write to status changed stored state");

  chk_wo_read_zero: assert property (
    rd_a && req_a_i.addr == OFS_CMD |=> rsp_o.valid && rsp_o.data == '0)
    else $error("command register read not zero");

  chk_rsvd_bits_zero: assert property (
    rsp_o.valid && rd_addr_reg == OFS_CTRL |-> rsp_o.data[DATA_W-1:3] == '0)
    else $error("reserved control bits read non-zero");

  chk_ro_field_legal: assert property (
    rsp_o.valid && rd_addr_reg == OFS_STATUS |-> rsp_o.data[STAT_MODE_LSB +: 2] != 2'h3)
    else $error("status mode field shows reserved code");

  chk_srst_loads: assert property (
    srst |=> ctrl_reg == CTRL_RST && flags_o == FLAGS_RST && !ext_level_reg)
    else $error("soft reset did not load reset values");

  chk_dbg_survives: assert property (
    srst && !(wr_a && req_a_i.addr == OFS_DBGCTRL)
         && !(wr_b && req_b_i.addr == OFS_DBGCTRL) |=> $stable(dbg_reg))
    else $error("debug control changed on soft reset");

  chk_clear_wins: assert property (
    !srst && (clr_mask != '0) |=> (flags_o & $past(clr_mask)) == '0)
    else $error("clear alias bit not cleared");

  chk_set_bits: assert property (
    !srst && (set_mask != '0)
    |=> (flags_o & ($past(set_mask) & ~$past(clr_mask)))
        == ($past(set_mask) & ~$past(clr_mask)))
    else $error("set alias bit not set");

  chk_alias_same: assert property (
    rd_a && (req_a_i.addr == OFS_FLAGS_SET || req_a_i.addr == OFS_CLEAR_ALIAS)
    |=> rsp_o.data == $past(flags_o))
    else $error("alias views differ");

  chk_zero_holds: assert property (
    !srst |=> ((flags_o ^ $past(flags_o)) & ~$past(set_mask | clr_mask)) == '0)
    else $error("unwritten flag bit changed");

  sequence s_status_read_done;
    rsp_o.valid && rd_addr_reg == OFS_STATUS;
  endsequence

  sequence s_alias_read_set;
    rd_a && req_a_i.addr == OFS_FLAGS_SET && !wr_b;
  endsequence

  sequence s_alias_read_clear;
    rd_a && req_a_i.addr == OFS_CLEAR_ALIAS && !wr_b;
  endsequence

  sequence s_pin_settled;
    !srst && ext_s2_reg == ext_s3_reg;
  endsequence

  sequence s_pin_moving;
    !srst && ext_s2_reg != ext_s3_reg;
  endsequence

  chk_ctrl_b_wins: assert property (
    wr_a && req_a_i.addr == OFS_CTRL && wr_b && req_b_i.addr == OFS_CTRL && !srst
    |=> ctrl_reg == ($past(req_b_i.wdata) & CTRL_USED_MASK))
    else $error("control register port priority wrong");

  chk_dbg_write: assert property (
    wr_a && req_a_i.addr == OFS_DBGCTRL && !wr_b
    |=> dbg_reg == ($past(req_a_i.wdata) & DBG_USED_MASK))
    else $error("debug control write not stored");

  chk_status_enable: assert property (
    s_status_read_done |-> rsp_o.data[STAT_EN_BIT] == $past(ctrl_reg[CTRL_EN_BIT]))
    else $error("status enable bit differs from control");

  chk_status_pin: assert property (
    s_status_read_done |-> rsp_o.data[STAT_EXT_BIT] == $past(ext_level_reg))
    else $error("status pin bit differs from filtered level");

  chk_status_rsvd: assert property (
    s_status_read_done |-> rsp_o.data[DATA_W-1:4] == '0)
    else $error("reserved status bits read non-zero");

  chk_dbg_rsvd: assert property (
    rsp_o.valid && rd_addr_reg == OFS_DBGCTRL |-> rsp_o.data[DATA_W-1:1] == '0)
    else $error("reserved debug bits read non-zero");

  chk_unmapped_zero: assert property (
    rd_a && req_a_i.addr > OFS_CLEAR_ALIAS |=> rsp_o.valid && rsp_o.data == '0)
    else $error("unmapped address read non-zero");

  chk_mode_idle_off: assert property (
    rsp_o.valid && rd_addr_reg == OFS_STATUS && !rsp_o.data[STAT_EN_BIT]
    |-> rsp_o.data[STAT_MODE_LSB +: 2] == MODE_IDLE)
    else $error("disabled status shows a mode other than idle");

  chk_alias_pair: assert property (
    s_alias_read_set ##1 s_alias_read_clear |=> rsp_o.data == $past(rsp_o.data))
    else $error("set and clear views read differently");

  chk_pin_follow: assert property (
    s_pin_settled |=> ext_level_reg == $past(ext_s3_reg))
    else $error("filtered pin level did not follow agreed input");

  chk_pin_hold: assert property (
    s_pin_moving |=> $stable(ext_level_reg))
    else $error("filtered pin level moved on disagreeing input");

endmodule : regconv_bank

// ### verif/regconv_bank_test.sv
// Self-checking bench for the register-convention bank.
// Assumes the bank's checks live in its own files; drives both ports at falling edges.
`timescale 1ns/1ps

`define CHECK(name, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("ERROR %s expected %h seen %h", name, exp, got); \
    end \
  end

module regconv_bank_test;
  import regconv_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk_sys_i;
  logic              rst_i;
  reg_req_t          req_a_i;
  reg_req_t          req_b_i;
  logic              ext_flag_i;
  reg_rsp_t          rsp_o;
  logic              ctrl_enable_o;
  logic [1:0]        ctrl_mode_o;
  logic              dbg_run_o;
  logic [DATA_W-1:0] flags_o;
  int                n_mismatch;
  int                cmp_count;
  int                cycles;

  regconv_bank u_regconv_bank (
    .clk_sys_i     (clk_sys_i),
    .rst_i         (rst_i),
    .req_a_i       (req_a_i),
    .req_b_i       (req_b_i),
    .ext_flag_i    (ext_flag_i),
    .rsp_o         (rsp_o),
    .ctrl_enable_o (ctrl_enable_o),
    .ctrl_mode_o   (ctrl_mode_o),
    .dbg_run_o     (dbg_run_o),
    .flags_o       (flags_o)
  );

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr2(input logic va, input logic [ADDR_W-1:0] aa, input logic [DATA_W-1:0] da,
                     input logic vb, input logic [ADDR_W-1:0] ab, input logic [DATA_W-1:0] db);
    @(negedge clk_sys_i);
    req_a_i = '{va, 1'b1, aa, da};
    req_b_i = '{vb, 1'b1, ab, db};
    @(negedge clk_sys_i);
    req_a_i = '0;
    req_b_i = '0;
  endtask : wr2

  task automatic wr_a(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    wr2(1'b1, ad, d, 1'b0, 4'h0, 8'h00);
  endtask : wr_a

  task automatic rd_a(input string nm, input logic [ADDR_W-1:0] ad,
                      input logic [DATA_W-1:0] exp);
    @(negedge clk_sys_i);
    req_a_i = '{1'b1, 1'b0, ad, 8'h00};
    @(negedge clk_sys_i);
    `CHECK(({nm, " valid"}), 1'b1, rsp_o.valid)
    `CHECK(nm, exp, rsp_o.data)
    req_a_i = '0;
    @(negedge clk_sys_i);
    `CHECK(({nm, " idle"}), 9'h000, rsp_o)
  endtask : rd_a

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values;
    `CHECK("flags out", FLAGS_RST, flags_o)
    `CHECK("dbg out", DBG_RST[0], dbg_run_o)
    rd_a("ctrl rst", OFS_CTRL, CTRL_RST);
    rd_a("dbg rst", OFS_DBGCTRL, DBG_RST);
    rd_a("flags rst", OFS_FLAGS_SET, FLAGS_RST);
  endtask : test_reset_values

  task automatic test_rw_reserved;
    wr_a(OFS_CTRL, 8'hFF);
    rd_a("ctrl rsv", OFS_CTRL, 8'h07);
    `CHECK("mode out", 2'h3, ctrl_mode_o)
    rd_a("status rsv mode", OFS_STATUS, 8'h01);
    wr_a(OFS_CTRL, 8'h05);
    rd_a("ctrl rw", OFS_CTRL, 8'h05);
    `CHECK("enable out", 1'b1, ctrl_enable_o)
    rd_a("status cont", OFS_STATUS, 8'h05);
    wr_a(OFS_STATUS, 8'hFF);
    rd_a("status ro", OFS_STATUS, 8'h05);
    wr_a(OFS_DBGCTRL, 8'hFF);
    rd_a("dbg rw", OFS_DBGCTRL, 8'h01);
    rd_a("cmd wo", OFS_CMD, 8'h00);
    rd_a("unmapped", 4'hA, 8'h00);
  endtask : test_rw_reserved

  task automatic test_set_clear;
    wr_a(OFS_FLAGS_SET, 8'hA5);
    `CHECK("flags set", 8'hA5, flags_o)
    rd_a("clr view", OFS_CLEAR_ALIAS, 8'hA5);
    wr_a(OFS_CLEAR_ALIAS, 8'h05);
    rd_a("set view", OFS_FLAGS_SET, 8'hA0);
    rd_a("clr view2", OFS_CLEAR_ALIAS, 8'hA0);
    wr_a(OFS_FLAGS_SET, 8'h00);
    wr_a(OFS_CLEAR_ALIAS, 8'h00);
    `CHECK("flags hold", 8'hA0, flags_o)
    wr2(1'b1, OFS_FLAGS_SET, 8'h0F, 1'b1, OFS_CLEAR_ALIAS, 8'h03);
    `CHECK("clear wins", 8'hAC, flags_o)
    wr2(1'b1, OFS_CLEAR_ALIAS, 8'h80, 1'b1, OFS_FLAGS_SET, 8'h90);
    `CHECK("clear wins b", 8'h3C, flags_o)
  endtask : test_set_clear

  task automatic test_soft_reset;
    wr_a(OFS_CTRL, 8'h03);
    wr_a(OFS_CMD, 8'h01);
    `CHECK("srst ctrl en", 1'b0, ctrl_enable_o)
    `CHECK("srst ctrl mode", 2'h0, ctrl_mode_o)
    `CHECK("srst flags", FLAGS_RST, flags_o)
    `CHECK("srst dbg", 1'b1, dbg_run_o)
    rd_a("srst dbg rd", OFS_DBGCTRL, 8'h01);
    rd_a("srst ctrl rd", OFS_CTRL, CTRL_RST);
    wr_a(OFS_CMD, 8'h00);
    `CHECK("cmd zero", 1'b1, dbg_run_o)
  endtask : test_soft_reset

  task automatic test_pin_status;
    ext_flag_i = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    rd_a("status pin", OFS_STATUS, 8'h08);
    wr_a(OFS_STATUS, 8'h00);
    rd_a("status pin ro", OFS_STATUS, 8'h08);
  endtask : test_pin_status

  task automatic test_back_to_back;
    wr_a(OFS_FLAGS_SET, 8'h5A);
    @(negedge clk_sys_i);
    req_a_i = '{1'b1, 1'b1, OFS_CTRL, 8'h05};
    @(negedge clk_sys_i);
    `CHECK("b2b mode", 2'h2, ctrl_mode_o)
    req_a_i = '{1'b1, 1'b0, OFS_CTRL, 8'h00};
    @(negedge clk_sys_i);
    `CHECK("b2b ctrl", 9'h105, rsp_o)
    req_a_i = '{1'b1, 1'b0, OFS_FLAGS_SET, 8'h00};
    @(negedge clk_sys_i);
    `CHECK("b2b set view", 9'h15A, rsp_o)
    req_a_i = '{1'b1, 1'b0, OFS_CLEAR_ALIAS, 8'h00};
    @(negedge clk_sys_i);
    `CHECK("b2b clr view", 9'h15A, rsp_o)
    req_a_i = '0;
    wr2(1'b1, OFS_CTRL, 8'h05, 1'b1, OFS_CTRL, 8'h03);
    `CHECK("port b wins", 2'h1, ctrl_mode_o)
    rd_a("status single", OFS_STATUS, 8'h0B);
  endtask : test_back_to_back

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst_i = 1'b1;
    req_a_i = '0;
    req_b_i = '0;
    ext_flag_i = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (6) @(negedge clk_sys_i);
    rst_i = 1'b0;
    test_reset_values();
    test_rw_reserved();
    test_set_clear();
    test_soft_reset();
    test_pin_status();
    test_back_to_back();
    report_and_stop();
  end

endmodule : regconv_bank_test
